// [verilog/int_seq_map.svh]
// Offsets, field positions and cycle counts of the interrupt sequencer
`ifndef INT_SEQ_MAP_SVH
`define INT_SEQ_MAP_SVH
`define OFS_INFO        5'h00
`define OFS_THRESH      5'h01
`define OFS_KEYDIR      5'h02
`define OFS_MATCH_EN    5'h03
`define OFS_MATCH0_LO   5'h04
`define OFS_MATCH0_HI   5'h05
`define OFS_MATCH1_LO   5'h06
`define OFS_MATCH1_HI   5'h07
`define OFS_REQ         5'h08
`define LEVEL_BLOCK_BIT 4
`define FLAG_I_BIT      6
`define FLAG_U_BIT      7
`define SPEC_RESET      0
`define SPEC_DBC        1
`define SPEC_WDT        2
`define SPEC_STEP       3
`define THRESH_RST      3'h0
`define KEYDIR_RST      8'h00
`define IPL_WDT         3'h7
`define IPL_RESET       3'h0
`define SWI_USP_FIRST   6'h20
`define ENTRY_BASE_CYC  5'h12
`define ENTRY_BUS8_CYC  5'h14
`define DBC_EXTRA_CYC   5'h02
`define ONE_EXTRA_CYC   5'h01
`define WR_FIRST_CYC    5'h02
`define VEC_RESET       6'h00
`define VEC_DBC         6'h01
`define VEC_WDT         6'h02
`define VEC_STEP        6'h03
`define VEC_MATCH       6'h04
`define VEC_MASK_BASE   6'h08
`endif

// [verilog/int_seq_pkg.sv]
// Types shared by the interrupt sequencer
package int_seq_pkg;
  typedef enum logic [2:0] {
    SRC_NONE, SRC_RESET, SRC_DBC, SRC_WDT, SRC_MASK, SRC_STEP, SRC_MATCH, SRC_SWI
  } src_e;
  typedef enum logic [2:0] {ST_IDLE, ST_ENTRY, ST_RET0, ST_RET1, ST_RET2} state_e;
  typedef logic [2:0] lvl_t;
endpackage : int_seq_pkg

// [verilog/key_edge.sv]
// Combined falling-edge detector for the eight key port pins
`timescale 1ns/1ps
`default_nettype none
module key_edge (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic [7:0] pins,
  input  wire logic [7:0] dir_in,
  output var  logic       edge_q
);
  // Pins set as output read as high, so they never mask the others
  wire logic all_high_w = &(pins | ~dir_in);
  logic      prev_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      prev_q <= 1'b1;
      edge_q <= 1'b0;
    end else if (ce) begin
      prev_q <= all_high_w;
      edge_q <= prev_q & ~all_high_w;
    end
  end
endmodule : key_edge
`default_nettype wire

// [verilog/int_seq.sv]
// Interrupt acceptance, entry sequencing, return and key/address-match sources
`timescale 1ns/1ps
`default_nettype none
`include "int_seq_map.svh"
module int_seq
  import int_seq_pkg::*;
#(
  parameter int N = 8
) (
  input  wire logic         CLOCK,
  input  wire logic         RSTN,
  input  wire logic         CE,
  input  wire logic [4:0]   ADDR,
  input  wire logic [15:0]  WDATA,
  input  wire logic         WR,
  input  wire logic         RD,
  output var  logic [15:0]  RDATA,
  input  wire logic [N-1:0] PERIPH_REQ,
  input  wire logic         RESET_REQ,
  input  wire logic         DBC_REQ,
  input  wire logic         WDT_REQ,
  input  wire logic         STEP_REQ,
  input  wire logic         SWI_REQ,
  input  wire logic [5:0]   SWI_NUM,
  input  wire logic         RETI_REQ,
  input  wire logic         INSTR_DONE,
  input  wire logic [15:0]  FLAG_WORD,
  input  wire logic [19:0]  PC,
  input  wire logic [15:0]  INTERRUPT_STACK_POINTER,
  input  wire logic [15:0]  USP,
  input  wire logic         BUS8,
  input  wire logic [19:0]  VECTOR_BASE,
  input  wire logic [7:0]   KEY_PINS,
  output var  logic [15:0]  MEM_ADDR,
  output var  logic [15:0]  MEM_WDATA,
  output var  logic         MEM_WR,
  output var  logic         MEM_RD,
  output var  logic         MEM_BYTE,
  input  wire logic [15:0]  MEM_RDATA,
  output var  logic         BUSY,
  output var  logic         ENTRY_DONE,
  output var  logic [5:0]   VEC_NUM,
  output var  logic [19:0]  VEC_ADDR,
  output var  logic [2:0]   THRESHOLD,
  output var  logic         RESTORE_VALID,
  output var  logic [15:0]  RESTORE_FLAG,
  output var  logic [19:0]  RESTORE_PC,
  output var  logic         KEY_WAKE
);
  if (N < 1 || N > 16) begin : g_bad_n
    $error("int_seq: N must lie in 1..16");
  end

  // Lowest index wins a tie because only a strictly higher level replaces it
  function automatic logic [7:0] pick_best(input logic [N-1:0] req,
                                           input logic [N-1:0][2:0] lv,
                                           input lvl_t thr);
    lvl_t       bl;
    logic [3:0] bi;
    logic       f;
    bl = thr;
    bi = 4'h0;
    f  = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (req[i] && lv[i] > bl) begin
        bl = lv[i];
        bi = 4'(i);
        f  = 1'b1;
      end
    end
    return {f, bi, bl};
  endfunction : pick_best

  function automatic logic [4:0] entry_cycles(input logic b8, input logic vodd,
                                              input logic sodd, input src_e s);
    logic [4:0] c;
    c = b8 ? `ENTRY_BUS8_CYC : `ENTRY_BASE_CYC + {4'h0, vodd} + {4'h0, sodd};
    if (s == SRC_DBC) c = c + `DBC_EXTRA_CYC;
    else if (s == SRC_MATCH || s == SRC_STEP) c = c + `ONE_EXTRA_CYC;
    return c;
  endfunction : entry_cycles

  state_e             state_q, state_d;
  src_e               src_q;
  logic [N-1:0]       req_q;
  logic [N-1:0][2:0]  level_q;
  logic [3:0]         spec_q;
  logic [7:0]         keydir_q;
  logic [1:0]         men_q;
  logic [19:0]        maddr0_q, maddr1_q;
  lvl_t               lvl_q;
  logic [4:0]         cnt_q, cyc_q;
  logic [15:0]        sp_q, push0_q, push1_q, pcl_q;
  logic               byte_q;
  logic               key_edge_w;

  key_edge u_key (
    .clk    (CLOCK),
    .rstn   (RSTN),
    .ce     (CE),
    .pins   (KEY_PINS),
    .dir_in (keydir_q),
    .edge_q (key_edge_w)
  );

  // Request resolution
  wire logic [7:0]   best_w      = pick_best(req_q, level_q, THRESHOLD);
  wire logic         best_f_w    = best_w[7];
  wire logic [3:0]   best_idx_w  = best_w[6:3];
  wire lvl_t         best_lvl_w  = best_w[2:0];
  wire logic [N-1:0] best_oh_w   = {{(N-1){1'b0}}, best_f_w} << best_idx_w;
  wire logic         match_hit_w = (men_q[0] && maddr0_q == PC) ||
                                   (men_q[1] && maddr1_q == PC);
  wire logic         iflag_w     = FLAG_WORD[`FLAG_I_BIT];
  wire src_e         sel_w = spec_q[`SPEC_RESET]  ? SRC_RESET :
                             spec_q[`SPEC_DBC]    ? SRC_DBC   :
                             spec_q[`SPEC_WDT]    ? SRC_WDT   :
                             (iflag_w && best_f_w) ? SRC_MASK  :
                             spec_q[`SPEC_STEP]   ? SRC_STEP  :
                             match_hit_w          ? SRC_MATCH : SRC_NONE;

  // Acceptance only at an instruction boundary
  wire logic start_w  = state_q == ST_IDLE && INSTR_DONE;
  wire logic go_swi_w = start_w && SWI_REQ;
  wire logic go_ret_w = start_w && !SWI_REQ && RETI_REQ;
  wire logic go_hw_w  = start_w && !SWI_REQ && !RETI_REQ && sel_w != SRC_NONE;
  wire logic go_ent_w = go_swi_w || go_hw_w;
  wire src_e ent_src_w = go_swi_w ? SRC_SWI : sel_w;
  wire logic [5:0] ent_num_w = go_swi_w             ? SWI_NUM :
                               sel_w == SRC_RESET   ? `VEC_RESET :
                               sel_w == SRC_DBC     ? `VEC_DBC :
                               sel_w == SRC_WDT     ? `VEC_WDT :
                               sel_w == SRC_MASK    ? `VEC_MASK_BASE + {2'h0, best_idx_w} :
                               sel_w == SRC_STEP    ? `VEC_STEP : `VEC_MATCH;
  wire logic use_usp_w = go_swi_w && SWI_NUM >= `SWI_USP_FIRST &&
                         FLAG_WORD[`FLAG_U_BIT];
  wire logic [15:0] ent_sp_w = use_usp_w ? USP : INTERRUPT_STACK_POINTER;
  wire logic [15:0] ret_sp_w = FLAG_WORD[`FLAG_U_BIT] ? USP : INTERRUPT_STACK_POINTER;
  wire logic [19:0] vec_addr_w = VECTOR_BASE + 20'({ent_num_w, 2'b00});
  wire logic [4:0]  cyc_w = entry_cycles(BUS8, vec_addr_w[0], ent_sp_w[0], ent_src_w);
  // First word carries the live threshold in the flag's level field
  wire logic [15:0] push0_w = {FLAG_WORD[15], THRESHOLD, PC[19:16], FLAG_WORD[7:0]};

  // Stack pushes: item 0 at SP-2, item 1 at SP-4; odd SP splits each in two bytes
  wire logic [4:0]  ws_w     = cnt_q - `WR_FIRST_CYC;
  wire logic        wr_now_w = state_q == ST_ENTRY && cnt_q >= `WR_FIRST_CYC &&
                               ws_w < (byte_q ? 5'h04 : 5'h02);
  wire logic        item_w   = byte_q ? ws_w[1] : ws_w[0];
  wire logic        hi_w     = byte_q & ws_w[0];
  wire logic [15:0] w_addr_w = sp_q - 16'h0002 - {14'h0, item_w, 1'b0} + {15'h0, hi_w};
  wire logic [15:0] w_word_w = item_w ? push1_q : push0_q;
  wire logic [15:0] w_data_w = !byte_q ? w_word_w :
                               hi_w ? {8'h00, w_word_w[15:8]} : {8'h00, w_word_w[7:0]};
  wire logic        last_w   = state_q == ST_ENTRY && cnt_q == cyc_q - 5'h01;

  // Register port
  wire logic info_rd_w = RD && ADDR == `OFS_INFO;
  // Widened compare so that N = 16 still reaches every level selector
  wire logic lvl_sel_w = ADDR[`LEVEL_BLOCK_BIT] && {1'b0, ADDR[3:0]} < 5'(N);
  wire logic lvl_wr_w  = WR && lvl_sel_w;
  wire logic acc_mask_w = go_hw_w && sel_w == SRC_MASK;
  wire logic [N-1:0] req_clr_w = ((acc_mask_w || info_rd_w) ? best_oh_w : '0) |
                                 ((WR && ADDR == `OFS_REQ) ? ~WDATA[N-1:0] : '0);
  wire logic [N-1:0] req_set_w = PERIPH_REQ | {{(N-1){1'b0}}, key_edge_w};
  wire logic [N-1:0] req_d     = (req_q & ~req_clr_w) | req_set_w;
  wire logic [3:0] spec_set_w = {STEP_REQ, WDT_REQ, DBC_REQ, RESET_REQ};
  wire logic [3:0] spec_clr_w = !go_hw_w ? 4'h0 :
                                sel_w == SRC_RESET ? 4'h1 : sel_w == SRC_DBC ? 4'h2 :
                                sel_w == SRC_WDT   ? 4'h4 : sel_w == SRC_STEP ? 4'h8 : 4'h0;
  wire logic [15:0] rdata_d =
      info_rd_w                 ? {7'h00, best_lvl_w, 6'(`VEC_MASK_BASE + {2'h0, best_idx_w})} :
      !RD                       ? 16'h0000 :
      ADDR == `OFS_THRESH       ? {13'h0, THRESHOLD} :
      ADDR == `OFS_KEYDIR       ? {8'h00, keydir_q} :
      ADDR == `OFS_MATCH_EN     ? {14'h0, men_q} :
      ADDR == `OFS_MATCH0_LO    ? maddr0_q[15:0] :
      ADDR == `OFS_MATCH0_HI    ? {12'h0, maddr0_q[19:16]} :
      ADDR == `OFS_MATCH1_LO    ? maddr1_q[15:0] :
      ADDR == `OFS_MATCH1_HI    ? {12'h0, maddr1_q[19:16]} :
      ADDR == `OFS_REQ          ? 16'(req_q) :
      lvl_sel_w                 ? {13'h0, level_q[ADDR[3:0]]} : 16'h0000;
  // Hardware updates take precedence over a software write in the same cycle
  wire lvl_t thr_d = (last_w && src_q == SRC_MASK)  ? lvl_q :
                     (last_w && src_q == SRC_WDT)   ? `IPL_WDT :
                     (last_w && src_q == SRC_RESET) ? `IPL_RESET :
                     state_q == ST_RET2 ? MEM_RDATA[14:12] :
                     (WR && ADDR == `OFS_THRESH) ? WDATA[2:0] : THRESHOLD;
  wire logic [15:0] mem_addr_d = go_ret_w ? ret_sp_w :
                                 state_q == ST_RET0 ? sp_q + 16'h0002 :
                                 wr_now_w ? w_addr_w : MEM_ADDR;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:  state_d = go_ent_w ? ST_ENTRY : go_ret_w ? ST_RET0 : ST_IDLE;
      ST_ENTRY: state_d = last_w ? ST_IDLE : ST_ENTRY;
      ST_RET0:  state_d = ST_RET1;
      ST_RET1:  state_d = ST_RET2;
      ST_RET2:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      keydir_q <= `KEYDIR_RST;
      men_q    <= 2'h0;
      maddr0_q <= 20'h00000;
      maddr1_q <= 20'h00000;
      level_q  <= '0;
      RDATA    <= 16'h0000;
    end else if (CE) begin
      if (WR && ADDR == `OFS_KEYDIR)    keydir_q <= WDATA[7:0];
      if (WR && ADDR == `OFS_MATCH_EN)  men_q <= WDATA[1:0];
      if (WR && ADDR == `OFS_MATCH0_LO) maddr0_q[15:0] <= WDATA;
      if (WR && ADDR == `OFS_MATCH0_HI) maddr0_q[19:16] <= WDATA[3:0];
      if (WR && ADDR == `OFS_MATCH1_LO) maddr1_q[15:0] <= WDATA;
      if (WR && ADDR == `OFS_MATCH1_HI) maddr1_q[19:16] <= WDATA[3:0];
      if (lvl_wr_w) level_q[ADDR[3:0]] <= WDATA[2:0];
      RDATA <= rdata_d;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      state_q   <= ST_IDLE;
      req_q     <= '0;
      spec_q    <= 4'h0;
      THRESHOLD <= `THRESH_RST;
      KEY_WAKE  <= 1'b0;
      cnt_q     <= 5'h00;
    end else if (CE) begin
      state_q   <= state_d;
      req_q     <= req_d;
      spec_q    <= (spec_q & ~spec_clr_w) | spec_set_w;
      THRESHOLD <= thr_d;
      KEY_WAKE  <= key_edge_w;
      cnt_q     <= go_ent_w ? 5'h00 : cnt_q + 5'h01;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      src_q   <= SRC_NONE;
      lvl_q   <= 3'h0;
      cyc_q   <= `ENTRY_BASE_CYC;
      sp_q    <= 16'h0000;
      byte_q  <= 1'b0;
      push0_q <= 16'h0000;
      push1_q <= 16'h0000;
      VEC_NUM <= 6'h00;
      VEC_ADDR <= 20'h00000;
    end else if (CE && (go_ent_w || go_ret_w)) begin
      src_q   <= ent_src_w;
      lvl_q   <= best_lvl_w;
      cyc_q   <= cyc_w;
      sp_q    <= go_ret_w ? ret_sp_w : ent_sp_w;
      byte_q  <= ent_sp_w[0];
      push0_q <= push0_w;
      push1_q <= PC[15:0];
      if (go_ent_w) begin
        VEC_NUM  <= ent_num_w;
        VEC_ADDR <= vec_addr_w;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      MEM_ADDR      <= 16'h0000;
      MEM_WDATA     <= 16'h0000;
      MEM_WR        <= 1'b0;
      MEM_RD        <= 1'b0;
      MEM_BYTE      <= 1'b0;
      BUSY          <= 1'b0;
      ENTRY_DONE    <= 1'b0;
      pcl_q         <= 16'h0000;
      RESTORE_VALID <= 1'b0;
      RESTORE_FLAG  <= 16'h0000;
      RESTORE_PC    <= 20'h00000;
    end else if (CE) begin
      MEM_ADDR   <= mem_addr_d;
      MEM_WDATA  <= wr_now_w ? w_data_w : MEM_WDATA;
      MEM_WR     <= wr_now_w;
      MEM_RD     <= go_ret_w || state_q == ST_RET0;
      MEM_BYTE   <= wr_now_w && byte_q;
      BUSY       <= go_ent_w || (state_q == ST_ENTRY && !last_w);
      ENTRY_DONE <= last_w;
      if (state_q == ST_RET1) pcl_q <= MEM_RDATA;
      RESTORE_VALID <= state_q == ST_RET2;
      if (state_q == ST_RET2) begin
        RESTORE_FLAG <= {MEM_RDATA[15:12], 4'h0, MEM_RDATA[7:0]};
        RESTORE_PC   <= {MEM_RDATA[11:8], pcl_q};
      end
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN || !CE);

  wire logic plain_w = go_hw_w && sel_w == SRC_MASK && !vec_addr_w[0] && !ent_sp_w[0];
  a_entry_even_16: assert property (plain_w && !BUS8 |-> ##18 BUSY ##1 !BUSY)
    else $error("16-bit even entry not 18 cycles");
  a_entry_bus8_len: assert property (plain_w && BUS8 |-> ##20 BUSY ##1 !BUSY)
    else $error("8-bit bus entry not 20 cycles");
  a_entry_dbc_len: assert property (go_hw_w && sel_w == SRC_DBC && !BUS8 && !vec_addr_w[0]
                     && !ent_sp_w[0] |-> ##20 BUSY ##1 !BUSY)
    else $error("break entry not 20 cycles");
  a_thresh_level_load: assert property (ENTRY_DONE && src_q == SRC_MASK |->
                                        THRESHOLD == lvl_q)
    else $error("threshold not loaded with accepted level");
  a_thresh_wdt_seven: assert property (ENTRY_DONE && src_q == SRC_WDT |->
                                       THRESHOLD == 3'h7)
    else $error("watchdog entry did not set threshold 7");
  a_push_byte_mode: assert property (MEM_WR |-> MEM_BYTE == sp_q[0])
    else $error("stack access width does not follow SP parity");
  a_reset_wins_all: assert property (go_hw_w && spec_q[`SPEC_RESET] |=>
                                     src_q == SRC_RESET)
    else $error("reset request not accepted first");
  a_mask_needs_iflag: assert property (go_hw_w && sel_w == SRC_MASK |->
                                       iflag_w && best_lvl_w > THRESHOLD)
    else $error("maskable accepted without enable or level");
  a_info_read_clear: assert property (info_rd_w && best_f_w && !go_hw_w &&
                       req_set_w == '0 && !(WR && ADDR == `OFS_REQ) |=>
                       $countones(req_q) == $countones($past(req_q)) - 1)
    else $error("info read did not clear one request bit");
  a_match_ignores_mask: assert property (go_hw_w && !spec_q[`SPEC_RESET] &&
                       !spec_q[`SPEC_DBC] && !spec_q[`SPEC_WDT] && !spec_q[`SPEC_STEP] &&
                       !(iflag_w && best_f_w) && match_hit_w |=> src_q == SRC_MATCH)
    else $error("address match not taken");
  a_swi_always_taken: assert property (start_w && SWI_REQ |=> BUSY && src_q == SRC_SWI)
    else $error("software interrupt did not enter");

  c_mask_entry: cover property (acc_mask_w ##[18:22] ENTRY_DONE);
  c_return_done: cover property (go_ret_w ##4 RESTORE_VALID);
  c_byte_push: cover property (MEM_WR && MEM_BYTE);
  c_key_wake: cover property (KEY_WAKE);
endmodule : int_seq
`default_nettype wire

// [verif/stack_mem.sv]
// Byte-addressed stack memory that answers the sequencer's stack accesses
`timescale 1ns/1ps
`default_nettype none
module stack_mem (
  input  wire logic        clk,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic        byte_en,
  output var  logic [15:0] rdata
);
  logic [7:0]  m [0:65535];
  int          nw     = 0;
  int          nb     = 0;
  logic        rd_q   = 1'b0;
  logic [15:0] a_q    = 16'h0000;
  logic [15:0] last_q = 16'h0000;
  always @(posedge clk) begin
    if (wr && byte_en) begin
      m[addr] <= wdata[7:0];
      nb <= nb + 1;
    end else if (wr) begin
      m[addr] <= wdata[7:0];
      m[addr + 16'h0001] <= wdata[15:8];
      nw <= nw + 1;
    end
    rd_q <= rd;
    a_q <= addr;
    if (rd_q) last_q <= rdata;
  end
  // Outside an answer the data lines show the inverse, so a late sample never matches by luck
  always_comb rdata = rd_q ? {m[a_q + 16'h0001], m[a_q]} : ~last_q;
endmodule : stack_mem
`default_nettype wire

// [verif/tb_int_seq.sv]
// Self-checking bench for the interrupt sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_int_seq;
  import int_seq_pkg::*;
  typedef struct packed {
    logic        b8;
    logic [19:0] vb;
    logic [15:0] sp;
    logic [3:0]  s;
    logic [5:0]  t;
    lvl_t        thr;
    logic [5:0]  vec;
  } row_s;
  logic        CLOCK, RSTN, CE, WR, RD, SWI_REQ, RETI_REQ, INSTR_DONE, BUS8;
  logic        RESET_REQ, DBC_REQ, WDT_REQ, STEP_REQ, MEM_WR, MEM_RD, MEM_BYTE;
  logic        BUSY, ENTRY_DONE, RESTORE_VALID, KEY_WAKE;
  logic [4:0]  ADDR;
  logic [15:0] WDATA, RDATA, FLAG_WORD, INTERRUPT_STACK_POINTER, USP, MEM_ADDR, MEM_WDATA, MEM_RDATA, RESTORE_FLAG, d;
  logic [19:0] PC, VECTOR_BASE, VEC_ADDR, RESTORE_PC;
  logic [7:0]  PERIPH_REQ, KEY_PINS;
  logic [5:0]  SWI_NUM, VEC_NUM;
  logic [2:0]  THRESHOLD, thr;
  int          t, b0, w0, k0;
  int          wakes = 0;
  int          error_cnt = 0;
  int          n_checks = 0;
  // Vector bases are mostly even; odd ones where the slow fetch is measured, and once on the 8-bit bus where it adds no cycle
  row_s rows [8] = '{
    '{1'b0, 20'h00400, 16'h0100, 4'h4, 6'h12, 3'h7, 6'h02},
    '{1'b0, 20'h00401, 16'h0100, 4'h2, 6'h15, 3'h7, 6'h01},
    '{1'b0, 20'h00400, 16'h0101, 4'h8, 6'h14, 3'h7, 6'h03},
    '{1'b0, 20'h00401, 16'h0101, 4'h1, 6'h14, 3'h0, 6'h00},
    '{1'b1, 20'h00401, 16'h0100, 4'h4, 6'h14, 3'h7, 6'h02},
    '{1'b1, 20'h00400, 16'h0101, 4'h2, 6'h16, 3'h7, 6'h01},
    '{1'b0, 20'h00400, 16'h0100, 4'ha, 6'h14, 3'h7, 6'h01},
    '{1'b0, 20'h00400, 16'h0100, 4'h0, 6'h13, 3'h7, 6'h03}};
  int_seq dut (.CLOCK, .RSTN, .CE, .ADDR, .WDATA, .WR, .RD, .RDATA, .PERIPH_REQ, .RESET_REQ,
    .DBC_REQ, .WDT_REQ, .STEP_REQ, .SWI_REQ, .SWI_NUM, .RETI_REQ, .INSTR_DONE, .FLAG_WORD, .PC,
    .INTERRUPT_STACK_POINTER, .USP, .BUS8, .VECTOR_BASE, .KEY_PINS, .MEM_ADDR, .MEM_WDATA, .MEM_WR, .MEM_RD, .MEM_BYTE,
    .MEM_RDATA, .BUSY, .ENTRY_DONE, .VEC_NUM, .VEC_ADDR, .THRESHOLD, .RESTORE_VALID, .RESTORE_FLAG,
    .RESTORE_PC, .KEY_WAKE);
  stack_mem sm (.clk(CLOCK), .addr(MEM_ADDR), .wdata(MEM_WDATA), .wr(MEM_WR), .rd(MEM_RD),
    .byte_en(MEM_BYTE), .rdata(MEM_RDATA));
  always @(negedge CLOCK) if (KEY_WAKE === 1'b1) wakes++;
  task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
    @(posedge CLOCK);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    @(negedge CLOCK);
    v = RDATA;
    @(posedge CLOCK);
  endtask : rd
  // Counts busy cycles of one entry; a refused request leaves the count at zero
  task automatic entry(input logic [3:0] s, output int n);
    {STEP_REQ, WDT_REQ, DBC_REQ, RESET_REQ} <= s;
    @(posedge CLOCK);
    {STEP_REQ, WDT_REQ, DBC_REQ, RESET_REQ} <= 4'h0;
    INSTR_DONE <= 1'b1;
    @(posedge CLOCK);
    INSTR_DONE <= 1'b0;
    n = 0;
    repeat (40) begin
      @(negedge CLOCK);
      if (ENTRY_DONE === 1'b1) break;
      if (BUSY === 1'b1) n++;
    end
    @(posedge CLOCK);
  endtask : entry
  task automatic stack_chk(input logic [15:0] sp, input logic [2:0] th);
    chk("saved flag word", {FLAG_WORD[15], th, PC[19:16], FLAG_WORD[7:0]},
        {sm.m[sp - 16'h1], sm.m[sp - 16'h2]});
    chk("saved pc", PC[15:0], {sm.m[sp - 16'h3], sm.m[sp - 16'h4]});
    chk("access count", sp[0] ? 20'h4 : 20'h2, 20'(sp[0] ? sm.nb - b0 : sm.nw - w0));
  endtask : stack_chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end
  // The whole run needs under a thousand cycles
  initial begin
    #250000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    {RSTN, WR, RD, SWI_REQ, RETI_REQ, INSTR_DONE, BUS8} = '0;
    {RESET_REQ, DBC_REQ, WDT_REQ, STEP_REQ} = '0;
    CE = 1'b1;
    {ADDR, WDATA, PERIPH_REQ, SWI_NUM} = '0;
    PC = 20'ha1234;
    FLAG_WORD = 16'h8035;
    {INTERRUPT_STACK_POINTER, USP} = {16'h0100, 16'h0200};
    VECTOR_BASE = 20'h00400;
    KEY_PINS = 8'hff;
    repeat (16) @(posedge CLOCK);
    RSTN <= 1'b1;
    @(posedge CLOCK);
    chk("reset threshold", 20'h0, THRESHOLD);
    rd(5'h02, d);
    chk("reset key direction", 20'h0, d);
    rd(5'h0f, d);
    chk("unmapped read", 20'h0, d);
    done("reset");
    thr = 3'h0;
    foreach (rows[i]) begin
      BUS8 <= rows[i].b8;
      VECTOR_BASE <= rows[i].vb;
      INTERRUPT_STACK_POINTER <= rows[i].sp;
      b0 = sm.nb;
      w0 = sm.nw;
      entry(rows[i].s, t);
      chk("entry cycles", rows[i].t, 20'(t));
      chk("vector number", rows[i].vec, VEC_NUM);
      chk("vector address", rows[i].vb + {rows[i].vec, 2'b00}, VEC_ADDR);
      chk("threshold", rows[i].thr, THRESHOLD);
      stack_chk(rows[i].sp, thr);
      thr = rows[i].thr;
    end
    done("entry table");
    wr(5'h13, 16'h0005);
    PERIPH_REQ <= 8'h08;
    FLAG_WORD <= 16'h8075;
    @(posedge CLOCK);
    PERIPH_REQ <= 8'h00;
    entry(4'h0, t);
    chk("blocked at seven", 20'h0, 20'(t));
    wr(5'h01, 16'h0002);
    FLAG_WORD <= 16'h8035;
    entry(4'h0, t);
    chk("blocked by flag", 20'h0, 20'(t));
    FLAG_WORD <= 16'h8075;
    entry(4'h0, t);
    chk("maskable cycles", 20'h12, 20'(t));
    chk("maskable vector", 20'h0b, VEC_NUM);
    chk("maskable level", 20'h5, THRESHOLD);
    done("maskable");
    wr(5'h11, 16'h0006);
    PERIPH_REQ <= 8'h02;
    @(posedge CLOCK);
    PERIPH_REQ <= 8'h00;
    rd(5'h08, d);
    chk("request bits", 20'h2, d);
    rd(5'h00, d);
    chk("info word", 20'h189, d);
    rd(5'h08, d);
    chk("request cleared", 20'h0, d);
    PERIPH_REQ <= 8'h06;
    @(posedge CLOCK);
    PERIPH_REQ <= 8'h00;
    wr(5'h08, 16'h0002);
    rd(5'h08, d);
    chk("software clear", 20'h2, d);
    BUS8 <= 1'b1;
    entry(4'h0, t);
    BUS8 <= 1'b0;
    chk("8-bit maskable cycles", 20'h14, 20'(t));
    chk("level six loaded", 20'h6, THRESHOLD);
    done("info read");
    FLAG_WORD <= 16'h8035;
    wr(5'h04, 16'h1234);
    wr(5'h05, 16'h000a);
    wr(5'h03, 16'h0001);
    entry(4'h0, t);
    wr(5'h03, 16'h0000);
    chk("match cycles", 20'h13, 20'(t));
    chk("match vector", 20'h04, VEC_NUM);
    chk("match keeps level", 20'h6, THRESHOLD);
    done("address match");
    FLAG_WORD <= 16'h80b5;
    SWI_NUM <= 6'h28;
    SWI_REQ <= 1'b1;
    b0 = sm.nb;
    w0 = sm.nw;
    entry(4'h0, t);
    SWI_REQ <= 1'b0;
    chk("software entry", 20'h12, 20'(t));
    chk("software vector", 20'h28, VEC_NUM);
    stack_chk(16'h0200, 3'h6);
    done("software interrupt");
    USP <= 16'h01fc;
    RETI_REQ <= 1'b1;
    INSTR_DONE <= 1'b1;
    @(posedge CLOCK);
    {INSTR_DONE, RETI_REQ} <= 2'b00;
    for (t = 1; t < 10; t++) begin
      @(negedge CLOCK);
      if (RESTORE_VALID === 1'b1) break;
    end
    chk("return delay", 20'h4, 20'(t));
    chk("restored pc", 20'ha1234, RESTORE_PC);
    chk("restored flags", 20'he0b5, RESTORE_FLAG);
    @(posedge CLOCK);
    done("return");
    wr(5'h02, 16'h000f);
    k0 = wakes;
    KEY_PINS <= 8'hef;
    repeat (4) @(posedge CLOCK);
    chk("output pin ignored", 20'(k0), 20'(wakes));
    KEY_PINS <= 8'hfb;
    repeat (4) @(posedge CLOCK);
    chk("key wake", 20'(k0 + 1), 20'(wakes));
    KEY_PINS <= 8'hf9;
    repeat (4) @(posedge CLOCK);
    chk("hidden edge", 20'(k0 + 1), 20'(wakes));
    KEY_PINS <= 8'hff;
    repeat (4) @(posedge CLOCK);
    done("key input");
    CE <= 1'b0;
    wr(5'h01, 16'h0003);
    CE <= 1'b1;
    rd(5'h01, d);
    chk("frozen threshold", 20'h6, d);
    done("clock enable");
    print_verdict();
  end
endmodule : tb_int_seq
`default_nettype wire
